/* rtl/ecrs_pkg.sv */
package ecrs_pkg;
  // number of programmable low reference steps
  localparam int          STEP_COUNT      = 16;
  // width of the stored step index
  localparam int          STEP_W          = 4;
  // reset value of the stored step (state one, 0.60 V)
  localparam logic [3:0]  STEP_DEFAULT    = 4'h0;
  // reference levels in millivolts
  localparam int          HIGH_REF_MV     = 1200;
  localparam int          LOW_BASE_MV     = 600;
  localparam int          LOW_STEP_MV     = 40;
  localparam int          REF_MV_W        = 11;
  // clock rate and period
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          CLK_NS          = 1_000_000_000 / CLK_HZ;
  // fastest legal programming edge rate: 1 MHz, period in ns
  localparam int          MAX_EDGE_HZ     = 1_000_000;
  localparam int          EDGE_PERIOD_NS  = 1_000_000_000 / MAX_EDGE_HZ;
  // latch hold time and shutdown time, in microseconds (defaults)
  localparam int          LATCH_HOLD_US   = 500;
  localparam int          SHUTDOWN_US     = 500;
  // derived counts: least times round up
  localparam int          LATCH_CYC       =
    (LATCH_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int          SHUT_CYC        =
    (SHUTDOWN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int          TIMER_W         = 16;
endpackage

/* rtl/ecrs_core.sv */
// Overview of operation
// - select high: high reference 1.2 V, low off
// - select low: low reference on, high off
// - select toggling switches setpoint with nothing else
// - count rising edges into sixteen states
// - level is 0.60 V plus 0.04 V steps
// - held high for latch time latches count
// - low beyond shutdown time disables device
// - disable resets stored step to default
// - power-up uses 0.6 V default low reference
`timescale 1ns/1ps
module ecrs_core
  import ecrs_pkg::*;
#(
  parameter int LATCH_CYCLES = LATCH_CYC, // hold-high time in cycles
  parameter int SHUT_CYCLES  = SHUT_CYC   // shutdown low time in cycles
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                en_set,       // single-wire enable/set pin
  input  wire logic                ref_select,   // reference select pin
  output logic                     device_on,    // converter enabled
  output logic                     high_feedback_reference_en,
  output logic                     low_feedback_reference_en,
  output logic [STEP_W-1:0]        low_ref_step, // latched step index
  output logic [REF_MV_W-1:0]      ref_mv        // active setpoint, mV
);

  // refuse counts the timer cannot hold or that are zero
  if (LATCH_CYCLES < 1 || LATCH_CYCLES >= (1 << TIMER_W) ||
      SHUT_CYCLES < 1 || SHUT_CYCLES >= (1 << TIMER_W)) begin : g_bad_count
    $error("ecrs_core: timer count out of range");
  end

  localparam logic [TIMER_W-1:0] LATCH_N = TIMER_W'(LATCH_CYCLES);
  localparam logic [TIMER_W-1:0] SHUT_N  = TIMER_W'(SHUT_CYCLES);

  logic                en_meta;     // first synchroniser stage
  logic                en_sync;     // second synchroniser stage
  logic                sel_meta;    // select first stage
  logic                sel_sync;    // select second stage
  logic                en_prev;     // previous synchronised level
  logic                rise;        // rising edge seen this cycle
  logic [TIMER_W-1:0]  level_timer; // cycles the line has stood level
  logic [STEP_W-1:0]   edge_count;  // edges in current burst, minus one
  logic                burst;       // edges pending latch
  logic                shut_due;    // line low for the shutdown time
  logic                latch_due;   // line high for the latch time

  // two flip-flops on each pin input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_meta  <= 1'b0;
      en_sync  <= 1'b0;
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end else begin
      en_meta  <= en_set;
      en_sync  <= en_meta;
      sel_meta <= ref_select;
      sel_sync <= sel_meta;
    end
  end

  // edge detect on the synchronised line
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_prev <= 1'b0;
    end else begin
      en_prev <= en_sync;
    end
  end
  assign rise = en_sync & ~en_prev;

  // timer tests skip the cycle of a level change: the timer then still
  // holds the length of the previous level, which would fake a timeout
  assign shut_due  = ~en_sync & ~en_prev & (level_timer >= SHUT_N - 1'b1);
  assign latch_due = en_sync & en_prev & burst &
                     (level_timer >= LATCH_N - 1'b1);

  // time the line has stood at its present level, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_timer <= '0;
    end else if (en_sync != en_prev) begin
      level_timer <= '0;
    end else if (level_timer != '1) begin
      level_timer <= level_timer + 1'b1;
    end
  end

  // device enable: first edge turns on, long low turns off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      device_on <= 1'b0;
    end else if (rise) begin
      device_on <= 1'b1;
    end else if (shut_due) begin
      device_on <= 1'b0;
    end
  end

  // burst edge counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edge_count <= STEP_DEFAULT;
      burst      <= 1'b0;
    end else if (shut_due) begin
      edge_count <= STEP_DEFAULT;
      burst      <= 1'b0;
    end else if (rise) begin
      // first edge of a burst counts as one, later ones add
      if (!burst) begin
        edge_count <= STEP_DEFAULT;
      end else begin
        edge_count <= edge_count + 1'b1;
      end
      burst <= 1'b1;
    end else if (latch_due) begin
      burst <= 1'b0;
    end
  end

  // latched step, reset to default on disable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_ref_step <= STEP_DEFAULT;
    end else if (shut_due) begin
      low_ref_step <= STEP_DEFAULT;
    end else if (latch_due) begin
      low_ref_step <= edge_count;
    end
  end

  // reference enables and setpoint follow select directly
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_feedback_reference_en <= 1'b0;
      low_feedback_reference_en  <= 1'b0;
      ref_mv                     <= REF_MV_W'(LOW_BASE_MV);
    end else begin
      high_feedback_reference_en <= sel_sync;
      low_feedback_reference_en  <= ~sel_sync;
      if (sel_sync) begin
        ref_mv <= REF_MV_W'(HIGH_REF_MV);
      end else begin
        ref_mv <= REF_MV_W'(LOW_BASE_MV
                            + LOW_STEP_MV * int'(low_ref_step));
      end
    end
  end

  // assertions
  property p_sel_high;
    @(posedge clk) disable iff (!rstn)
      sel_sync |=> high_feedback_reference_en && !low_feedback_reference_en
                   && ref_mv == REF_MV_W'(1200);
  endproperty
  a_sel_high: assert property (p_sel_high)
    else $error("high ref wrong");

  property p_sel_low;
    @(posedge clk) disable iff (!rstn)
      !sel_sync |=> low_feedback_reference_en && !high_feedback_reference_en;
  endproperty
  a_sel_low: assert property (p_sel_low)
    else $error("low ref wrong");

  property p_toggle;
    @(posedge clk) disable iff (!rstn)
      $rose(sel_sync) |=> $rose(high_feedback_reference_en);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("select toggle lost");

  property p_low_level;
    @(posedge clk) disable iff (!rstn)
      !sel_sync |=> ref_mv ==
        REF_MV_W'(600 + 40 * int'($past(low_ref_step)));
  endproperty
  a_low_level: assert property (p_low_level)
    else $error("low level wrong");

  property p_count;
    @(posedge clk) disable iff (!rstn)
      rise && burst |=> edge_count == $past(edge_count) + 1'b1;
  endproperty
  a_count: assert property (p_count)
    else $error("edge not counted");

  property p_wrap;
    @(posedge clk) disable iff (!rstn)
      rise && burst && edge_count == 4'hF |=> edge_count == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("no wrap");

  sequence s_latch_due;
    en_sync && en_prev && burst && level_timer >= LATCH_N - 1'b1;
  endsequence
  property p_latch;
    @(posedge clk) disable iff (!rstn)
      s_latch_due |=> low_ref_step == $past(edge_count) && !burst;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch missed");

  sequence s_shut_due;
    !en_sync && !en_prev && level_timer >= SHUT_N - 1'b1;
  endsequence
  property p_shut;
    @(posedge clk) disable iff (!rstn)
      s_shut_due |=> !device_on && low_ref_step == 4'h0;
  endproperty
  a_shut: assert property (p_shut)
    else $error("shutdown missed");

  property p_first_edge;
    @(posedge clk) disable iff (!rstn)
      rise && !burst |=> device_on && edge_count == 4'h0 && burst;
  endproperty
  a_first_edge: assert property (p_first_edge)
    else $error("first edge");

endmodule

/* sim/ecrs_host.sv */
`timescale 1ns/1ps
// host model driving the enable/set line and the select pin
module ecrs_host #(
  parameter int HOLD = 44 // high hold after last pulse, cycles
) (
  input  wire logic clk,
  output logic      en_set,
  output logic      ref_select
);
  // both pins idle low until the first command
  initial begin
    en_set = 1'b0;
    ref_select = 1'b0;
  end
  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // n pulses of 5 cycles high, 5 low between, then held high so the count latches
  task automatic burst(input int n);
    ref_select = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        en_set = 1'b0;
        tick(5);
      end
      en_set = 1'b1;
      tick(5);
    end
    tick(HOLD);
  endtask
  // two pulses split by a long low gap, then held high to latch
  task automatic gap_pair(input int gap);
    ref_select = 1'b0;
    en_set = 1'b1;
    tick(5);
    en_set = 1'b0;
    tick(gap);
    en_set = 1'b1;
    tick(5);
    tick(HOLD);
  endtask
  // line held low for n cycles
  task automatic low(input int n);
    en_set = 1'b0;
    tick(n);
  endtask
  // select pin level
  task automatic sel(input logic v);
    ref_select = v;
    tick(4);
  endtask
endmodule

/* sim/edge_count_reference_setter_test.sv */
`timescale 1ns/1ps
module edge_count_reference_setter_test;
  import ecrs_pkg::*;
  logic                clk;
  logic                rstn;
  logic                en_set;
  logic                ref_select;
  logic                device_on;
  logic                hi_en;
  logic                lo_en;
  logic [STEP_W-1:0]   step;
  logic [REF_MV_W-1:0] mv;
  int                  err_total = 0;
  int                  checks = 0;
  int                  cyc = 0;
  // short latch and shutdown times keep the run brief
  localparam int       LAT_T = 40;
  localparam int       OFF_T = 60;
  ecrs_core #(.LATCH_CYCLES(LAT_T), .SHUT_CYCLES(OFF_T)) dut (
    .clk(clk), .rstn(rstn), .en_set(en_set), .ref_select(ref_select),
    .device_on(device_on), .high_feedback_reference_en(hi_en),
    .low_feedback_reference_en(lo_en), .low_ref_step(step), .ref_mv(mv));
  ecrs_host #(.HOLD(LAT_T + 4)) host (
    .clk(clk), .en_set(en_set), .ref_select(ref_select));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string what, input logic [10:0] exp,
                     input logic [10:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      end_of_test();
    end
  end
  // bursts of several lengths, including the wrap past sixteen
  task automatic t_prog;
    int tbl[5] = '{1, 2, 9, 16, 17};
    int s;
    foreach (tbl[i]) begin
      host.low(OFF_T + 10);
      host.burst(tbl[i]);
      s = (tbl[i] - 1) % 16;
      chk("on", 11'h1, 11'(device_on));
      chk("step", 11'(s), 11'(step));
      chk("mv", 11'(LOW_BASE_MV + LOW_STEP_MV * s), mv);
    end
  endtask
  // select toggling between the two setpoints
  task automatic t_sel;
    host.low(OFF_T + 10);
    host.burst(9);
    host.sel(1'b1);
    chk("hi_en", 11'h1, 11'(hi_en));
    chk("lo_en", 11'h0, 11'(lo_en));
    chk("mv", 11'(HIGH_REF_MV), mv);
    host.sel(1'b0);
    chk("lo_en", 11'h1, 11'(lo_en));
    chk("mv", 11'(LOW_BASE_MV + LOW_STEP_MV * 8), mv);
  endtask
  // a low gap longer than the latch time but short of shutdown counts
  task automatic t_gap;
    host.low(OFF_T + 10);
    host.gap_pair(OFF_T - 10);
    chk("on", 11'h1, 11'(device_on));
    chk("step", 11'h1, 11'(step));
    chk("mv", 11'(LOW_BASE_MV + LOW_STEP_MV), mv);
  endtask
  // a short low keeps the device on, a long one shuts it and clears
  task automatic t_off;
    host.low(OFF_T - 10);
    chk("on", 11'h1, 11'(device_on));
    host.low(OFF_T / 3);
    chk("on", 11'h0, 11'(device_on));
    chk("step", 11'h0, 11'(step));
    host.burst(1);
    chk("mv", 11'(LOW_BASE_MV), mv);
  endtask
  // reset, then scenarios in turn
  initial begin
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    host.tick(4);
    chk("on", 11'h0, 11'(device_on));
    chk("mv", 11'(LOW_BASE_MV), mv);
    t_prog();
    t_sel();
    t_gap();
    t_off();
    end_of_test();
  end
endmodule
